/* File: core/ovf_pkg.sv */
// How it works
// - Command bit 1 gates memory window response
// - Command bit 0 gates I/O range decode
// - Command bits 15:2 always read zero
// - Status error bits always read zero
// - Select timing field reads 00, fast
// - Status bit 7 reads one; status 0080h
// - Vendor code is fixed 16-bit constant
// - Device code is fixed 16-bit constant
// - Board tags take one write, then lock
// - Base register claims 4 KB, bits 31:12
package ovf_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [5:0]  dw_index_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0]  byte_en_t;
  typedef logic [15:0] half_t;

  typedef enum logic [1:0] {
    TAG_OPEN   = 2'b01,
    TAG_LOCKED = 2'b10
  } tag_state_t;

  // ****************************************
  // Byte offsets of the header
  // ****************************************
  localparam logic [7:0] OFS_VENDOR       = 8'h00;
  localparam logic [7:0] OFS_DEVICE       = 8'h02;
  localparam logic [7:0] OFS_COMMAND      = 8'h04;
  localparam logic [7:0] OFS_STATUS       = 8'h06;
  localparam logic [7:0] OFS_REVISION     = 8'h08;
  localparam logic [7:0] OFS_SUB_CLASS    = 8'h0A;
  localparam logic [7:0] OFS_BASE_CLASS   = 8'h0B;
  localparam logic [7:0] OFS_HEADER       = 8'h0E;
  localparam logic [7:0] OFS_BAR          = 8'h10;
  localparam logic [7:0] OFS_BOARD_VENDOR = 8'h2C;
  localparam logic [7:0] OFS_BOARD_SUBSYS = 8'h2E;

  // Dword indices of the config port
  localparam dw_index_t DW_IDENT   = OFS_VENDOR[7:2];
  localparam dw_index_t DW_CMDSTS  = OFS_COMMAND[7:2];
  localparam dw_index_t DW_CLASS   = OFS_REVISION[7:2];
  localparam dw_index_t DW_HEADER  = OFS_HEADER[7:2];
  localparam dw_index_t DW_BAR     = OFS_BAR[7:2];
  localparam dw_index_t DW_BOARD   = OFS_BOARD_VENDOR[7:2];

  // ****************************************
  // Field positions and values
  // ****************************************
  localparam int          CMD_IO_BIT       = 0;
  localparam int          CMD_MEM_BIT      = 1;
  localparam int          BAR_BASE_LSB     = 12;
  localparam int          BAR_BASE_W       = 20;
  localparam logic [15:0] COMMAND_RST      = 16'h0000;
  localparam logic [15:0] STATUS_VALUE     = 16'h0080;
  localparam logic [7:0]  SUB_CLASS_VALUE  = 8'h80;
  localparam logic [7:0]  BASE_CLASS_VALUE = 8'h08;
  localparam logic [7:0]  HEADER_VALUE     = 8'h00;
  localparam logic [19:0] BAR_BASE_RST     = 20'h0_0000;
  localparam logic [11:0] BAR_LOW_BITS     = 12'h000;
  localparam logic [15:0] BOARD_TAG_RST    = 16'h0000;
  localparam word_t       WORD_ZERO        = 32'h0000_0000;

endpackage : ovf_pkg

/* File: core/cfg_tag_if.sv */
`timescale 1ns/10ps
interface cfg_tag_if;
  logic              wr;
  logic [1:0]        be;
  ovf_pkg::half_t    wdata;
  ovf_pkg::half_t    value;
  logic              locked;

  modport owner (output wr, output be, output wdata, input value, input locked);
  modport store (input wr, input be, input wdata, output value, output locked);
endinterface : cfg_tag_if

/* File: core/write_once_tag.sv */
`timescale 1ns/10ps
module write_once_tag (
  input wire logic   clk_in,
  input wire logic   reset_n_in,
  input wire logic   ce_in,
  cfg_tag_if.store   tag_port
);
  import ovf_pkg::*;

  tag_state_t  state_r;
  half_t       value_r;

  // ****************************************
  // Lock state
  // ****************************************
  // Any enabled byte locks the whole field
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= TAG_OPEN;
    end else if (ce_in) begin
      case (state_r)
        TAG_OPEN: begin
          if (tag_port.wr && |tag_port.be) begin
            state_r <= TAG_LOCKED;
          end
        end
        TAG_LOCKED: state_r <= TAG_LOCKED;
        default:    state_r <= TAG_OPEN;
      endcase
    end
  end

  // ****************************************
  // Stored value, per byte
  // ****************************************
  genvar b;
  generate
    for (b = 0; b < 2; b++) begin : g_byte
      always_ff @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          value_r[b*8 +: 8] <= BOARD_TAG_RST[b*8 +: 8];
        end else if (ce_in && tag_port.wr && tag_port.be[b] && state_r == TAG_OPEN) begin
          value_r[b*8 +: 8] <= tag_port.wdata[b*8 +: 8];
        end
      end
    end
  endgenerate

  assign tag_port.value  = value_r;
  assign tag_port.locked = (state_r == TAG_LOCKED);

  // ****************************************
  // Checks
  // ****************************************
  property p_tag_first_write_locks;
    @(posedge clk_in) disable iff (!reset_n_in)
      ce_in && tag_port.wr && |tag_port.be && state_r == TAG_OPEN |=> state_r == TAG_LOCKED;
  endproperty
  a_tag_first_write_locks: assert property (p_tag_first_write_locks)
    else $error("Board tag did not lock after its first write");

  property p_tag_locked_frozen;
    @(posedge clk_in) disable iff (!reset_n_in)
      state_r == TAG_LOCKED |=> state_r == TAG_LOCKED && $stable(value_r);
  endproperty
  a_tag_locked_frozen: assert property (p_tag_locked_frozen)
    else $error("Locked board tag changed");

  c_tag_lock: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    $rose(state_r == TAG_LOCKED));

endmodule : write_once_tag

/* File: core/overflow_device_config_header.sv */
`timescale 1ns/10ps
module overflow_device_config_header #(
  parameter logic [15:0] VENDOR_CODE   = 16'h1234, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE   = 16'h5678, // Arbitrary value
  parameter logic [7:0]  REVISION_CODE = 8'h01     // Arbitrary value
) (
  input  wire logic               clk_in,
  input  wire logic               reset_n_in,
  input  wire logic               ce_in,
  input  wire logic               cfg_req_in,
  input  wire logic               cfg_we_in,
  input  wire ovf_pkg::dw_index_t cfg_dw_in,
  input  wire ovf_pkg::byte_en_t  cfg_be_in,
  input  wire ovf_pkg::word_t     cfg_wdata_in,
  output logic                    cfg_ack_out,
  output ovf_pkg::word_t          cfg_rdata_out,
  input  wire logic               mem_req_in,
  input  wire ovf_pkg::word_t     mem_addr_in,
  output logic                    mem_hit_out,
  input  wire logic               io_req_in,
  input  wire ovf_pkg::half_t     io_addr_in,
  input  wire ovf_pkg::half_t     io_range_lower_bound_in,
  input  wire ovf_pkg::half_t     io_range_upper_bound_in,
  output logic                    io_hit_out,
  output logic                    memory_space_enable_out,
  output logic                    io_space_enable_out
);
  import ovf_pkg::*;

  logic                  memory_space_enable_r;
  logic                  io_space_enable_r;
  logic [BAR_BASE_W-1:0] bar_base_r;
  logic                  ack_r;
  word_t                 rdata_r;
  word_t                 rdata_nxt;
  logic                  mem_hit_r;
  logic                  io_hit_r;
  logic                  cfg_write;
  logic                  cfg_read;
  half_t                 command_view;
  word_t                 bar_view;

  cfg_tag_if vendor_tag_bus ();
  cfg_tag_if subsys_tag_bus ();

  assign cfg_write = ce_in && cfg_req_in && cfg_we_in;
  assign cfg_read  = ce_in && cfg_req_in && !cfg_we_in;

  // ****************************************
  // Command register
  // ****************************************
  // Only bits 1:0 are storage; all else is ignored on write
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      memory_space_enable_r <= COMMAND_RST[CMD_MEM_BIT];
      io_space_enable_r     <= COMMAND_RST[CMD_IO_BIT];
    end else if (cfg_write && cfg_dw_in == DW_CMDSTS && cfg_be_in[0]) begin
      memory_space_enable_r <= cfg_wdata_in[CMD_MEM_BIT];
      io_space_enable_r     <= cfg_wdata_in[CMD_IO_BIT];
    end
  end

  always_comb begin
    command_view              = 16'h0000;
    command_view[CMD_MEM_BIT] = memory_space_enable_r;
    command_view[CMD_IO_BIT]  = io_space_enable_r;
  end

  // ****************************************
  // Memory window base
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      bar_base_r <= BAR_BASE_RST;
    end else if (cfg_write && cfg_dw_in == DW_BAR) begin
      if (cfg_be_in[1]) begin
        bar_base_r[3:0] <= cfg_wdata_in[15:12];
      end
      if (cfg_be_in[2]) begin
        bar_base_r[11:4] <= cfg_wdata_in[23:16];
      end
      if (cfg_be_in[3]) begin
        bar_base_r[19:12] <= cfg_wdata_in[31:24];
      end
    end
  end

  // Low twelve bits fixed: 4 KB, 32-bit, non-prefetchable memory
  assign bar_view = {bar_base_r, BAR_LOW_BITS};

  // ****************************************
  // Write-once board tags
  // ****************************************
  assign vendor_tag_bus.wr    = cfg_write && cfg_dw_in == DW_BOARD;
  assign vendor_tag_bus.be    = cfg_be_in[1:0];
  assign vendor_tag_bus.wdata = cfg_wdata_in[15:0];
  assign subsys_tag_bus.wr    = cfg_write && cfg_dw_in == DW_BOARD;
  assign subsys_tag_bus.be    = cfg_be_in[3:2];
  assign subsys_tag_bus.wdata = cfg_wdata_in[31:16];

  write_once_tag u_vendor_tag (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .tag_port   (vendor_tag_bus.store)
  );

  write_once_tag u_subsys_tag (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .ce_in      (ce_in),
    .tag_port   (subsys_tag_bus.store)
  );

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rdata_nxt = WORD_ZERO;
    case (cfg_dw_in)
      DW_IDENT:  rdata_nxt = {DEVICE_CODE, VENDOR_CODE};
      DW_CMDSTS: rdata_nxt = {STATUS_VALUE, command_view};
      DW_CLASS:  rdata_nxt = {BASE_CLASS_VALUE, SUB_CLASS_VALUE, 8'h00, REVISION_CODE};
      DW_HEADER: rdata_nxt = {8'h00, HEADER_VALUE, 16'h0000};
      DW_BAR:    rdata_nxt = bar_view;
      DW_BOARD:  rdata_nxt = {subsys_tag_bus.value, vendor_tag_bus.value};
      default:   rdata_nxt = WORD_ZERO;
    endcase
  end

  // Data holds until the next read so a slow requester can sample late
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= WORD_ZERO;
    end else if (cfg_read) begin
      rdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_r <= 1'b0;
    end else if (ce_in) begin
      ack_r <= cfg_req_in;
    end
  end

  // ****************************************
  // Address decode
  // ****************************************
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      mem_hit_r <= 1'b0;
    end else if (ce_in) begin
      mem_hit_r <= mem_req_in && memory_space_enable_r &&
                   mem_addr_in[31:BAR_BASE_LSB] == bar_base_r;
    end
  end

  // Unsigned bounds; an inverted range claims nothing
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      io_hit_r <= 1'b0;
    end else if (ce_in) begin
      io_hit_r <= io_req_in && io_space_enable_r &&
                  io_addr_in >= io_range_lower_bound_in &&
                  io_addr_in <= io_range_upper_bound_in;
    end
  end

  assign cfg_ack_out             = ack_r;
  assign cfg_rdata_out           = rdata_r;
  assign mem_hit_out             = mem_hit_r;
  assign io_hit_out              = io_hit_r;
  assign memory_space_enable_out = memory_space_enable_r;
  assign io_space_enable_out     = io_space_enable_r;

  // ****************************************
  // Checks
  // ****************************************
  logic fresh_r;

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fresh_r <= 1'b1;
    end else begin
      fresh_r <= 1'b0;
    end
  end

  property p_mem_gated;
    @(posedge clk_in) disable iff (!reset_n_in)
      ce_in && !memory_space_enable_r |=> !mem_hit_out;
  endproperty
  a_mem_gated: assert property (p_mem_gated)
    else $error("Memory hit while memory space disabled");

  property p_mem_hits;
    @(posedge clk_in) disable iff (!reset_n_in)
      ce_in && mem_req_in && memory_space_enable_r &&
      mem_addr_in[31:BAR_BASE_LSB] == bar_base_r |=> mem_hit_out;
  endproperty
  a_mem_hits: assert property (p_mem_hits)
    else $error("Enabled memory window access not claimed");

  property p_io_gated;
    @(posedge clk_in) disable iff (!reset_n_in)
      ce_in && (!io_space_enable_r || io_addr_in < io_range_lower_bound_in) |=> !io_hit_out;
  endproperty
  a_io_gated: assert property (p_io_gated)
    else $error("I/O hit while disabled or below range");

  property p_command_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_read && cfg_dw_in == DW_CMDSTS |=>
        cfg_ack_out && cfg_rdata_out[15:2] == 14'h0000 &&
        cfg_rdata_out[1:0] == $past({memory_space_enable_r, io_space_enable_r});
  endproperty
  a_command_read: assert property (p_command_read)
    else $error("Command read shows hardwired bits set or wrong enables");

  property p_status_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_read && cfg_dw_in == DW_CMDSTS |=>
        cfg_rdata_out[31:27] == 5'h00 && cfg_rdata_out[24] == 1'b0;
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("Status error bit reads nonzero");

  property p_status_timing;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_read && cfg_dw_in == DW_CMDSTS |=>
        cfg_rdata_out[26:25] == 2'b00 && cfg_rdata_out[23] &&
        cfg_rdata_out[31:16] == 16'h0080;
  endproperty
  a_status_timing: assert property (p_status_timing)
    else $error("Status does not read 0080h");

  property p_ident_read;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_read && cfg_dw_in == DW_IDENT |=>
        cfg_rdata_out[15:0] == VENDOR_CODE && cfg_rdata_out[31:16] == DEVICE_CODE;
  endproperty
  a_ident_read: assert property (p_ident_read)
    else $error("Identification word wrong");

  property p_board_locks;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_write && cfg_dw_in == DW_BOARD && cfg_be_in == 4'hF ##1
      cfg_write && cfg_dw_in == DW_BOARD && cfg_be_in == 4'hF |=>
        $stable({subsys_tag_bus.value, vendor_tag_bus.value});
  endproperty
  a_board_locks: assert property (p_board_locks)
    else $error("Second board tag write took effect");

  property p_bar_low_zero;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_read && cfg_dw_in == DW_BAR |=> cfg_rdata_out[11:0] == 12'h000 &&
        cfg_rdata_out[31:12] == $past(bar_base_r);
  endproperty
  a_bar_low_zero: assert property (p_bar_low_zero)
    else $error("Base register read wrong");

  property p_reserved_zero;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_read && cfg_dw_in > DW_BAR && cfg_dw_in != DW_BOARD |=> cfg_rdata_out == WORD_ZERO;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("Reserved location reads nonzero");

  property p_reset_defaults;
    @(posedge clk_in) disable iff (!reset_n_in)
      fresh_r |-> !memory_space_enable_r && !io_space_enable_r &&
        bar_base_r == BAR_BASE_RST && !vendor_tag_bus.locked && !subsys_tag_bus.locked;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("Writable state not at default after reset");

  property p_command_write;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_write && cfg_dw_in == DW_CMDSTS && cfg_be_in[0] |=>
        memory_space_enable_out == $past(cfg_wdata_in[CMD_MEM_BIT]) &&
        io_space_enable_out == $past(cfg_wdata_in[CMD_IO_BIT]);
  endproperty
  a_command_write: assert property (p_command_write)
    else $error("Command enables did not take the written value");

  // Lane 0 of the command dword is the only way to move the enables
  property p_command_ignored;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_write && !(cfg_dw_in == DW_CMDSTS && cfg_be_in[0]) |=>
        $stable({memory_space_enable_r, io_space_enable_r});
  endproperty
  a_command_ignored: assert property (p_command_ignored)
    else $error("Enables changed by a write that does not reach them");

  property p_io_above;
    @(posedge clk_in) disable iff (!reset_n_in)
      ce_in && io_addr_in > io_range_upper_bound_in |=> !io_hit_out;
  endproperty
  a_io_above: assert property (p_io_above)
    else $error("I/O hit above range");

  property p_bar_write;
    @(posedge clk_in) disable iff (!reset_n_in)
      cfg_write && cfg_dw_in == DW_BAR && cfg_be_in[3] |=>
        bar_base_r[19:12] == $past(cfg_wdata_in[31:24]);
  endproperty
  a_bar_write: assert property (p_bar_write)
    else $error("Base register top byte not written");

  // Low enable must hold the base register, read data, hits and ack
  property p_frozen;
    @(posedge clk_in) disable iff (!reset_n_in)
      !ce_in |=> $stable({bar_base_r, cfg_ack_out, cfg_rdata_out, mem_hit_out, io_hit_out});
  endproperty
  a_frozen: assert property (p_frozen)
    else $error("State moved while clock enable low");

  c_mem_hit: cover property (@(posedge clk_in) disable iff (!reset_n_in) mem_hit_out);
  c_io_hit: cover property (@(posedge clk_in) disable iff (!reset_n_in) io_hit_out);
  c_board_read: cover property (@(posedge clk_in) disable iff (!reset_n_in)
    vendor_tag_bus.locked && cfg_read && cfg_dw_in == DW_BOARD);

endmodule : overflow_device_config_header

/* File: dv/overflow_device_config_header_test.sv */
`timescale 1ns/10ps
module overflow_device_config_header_test;
  import ovf_pkg::*;

  `define CHK(got, exp) begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
  end

  localparam logic [15:0] VEND = 16'hA5C3; // Arbitrary value
  localparam logic [15:0] DEV  = 16'h3C5A; // Arbitrary value
  localparam logic [7:0]  REV  = 8'h4D;    // Arbitrary value

  // *****
  // Stimulus and model state
  // *****
  logic        clk_in      = 1'b0;
  logic        reset_n_in  = 1'b0;
  logic        ce_in       = 1'b1;
  logic        cfg_req     = 1'b0;
  logic        cfg_we      = 1'b0;
  logic        mem_req     = 1'b0;
  logic        io_req      = 1'b0;
  dw_index_t   cfg_dw      = '0;
  byte_en_t    cfg_be      = '0;
  word_t       cfg_wdata   = '0;
  word_t       mem_addr    = '0;
  half_t       io_addr     = '0;
  half_t       io_lo       = '0;
  half_t       io_hi       = '0;
  logic        cfg_ack;
  word_t       cfg_rdata;
  logic        mem_hit;
  logic        io_hit;
  logic        mem_en;
  logic        io_en;
  logic [1:0]  cmd_r;
  logic [19:0] bar_r;
  half_t       vtag_r;
  half_t       stag_r;
  logic        vlock_r;
  logic        slock_r;
  logic [31:0] seed_r = 32'h2877_d1d1;
  int          n_mismatch      = 0;
  int          samples_checked = 0;

  overflow_device_config_header #(.VENDOR_CODE(VEND), .DEVICE_CODE(DEV), .REVISION_CODE(REV)) dut (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce_in),
    .cfg_req_in(cfg_req), .cfg_we_in(cfg_we), .cfg_dw_in(cfg_dw), .cfg_be_in(cfg_be),
    .cfg_wdata_in(cfg_wdata), .cfg_ack_out(cfg_ack), .cfg_rdata_out(cfg_rdata),
    .mem_req_in(mem_req), .mem_addr_in(mem_addr), .mem_hit_out(mem_hit),
    .io_req_in(io_req), .io_addr_in(io_addr), .io_range_lower_bound_in(io_lo),
    .io_range_upper_bound_in(io_hi), .io_hit_out(io_hit),
    .memory_space_enable_out(mem_en), .io_space_enable_out(io_en));

  always #5 clk_in = ~clk_in;

  function automatic logic [31:0] next_rand();
    seed_r = seed_r ^ (seed_r << 13);
    seed_r = seed_r ^ (seed_r >> 17);
    seed_r = seed_r ^ (seed_r << 5);
    return seed_r;
  endfunction : next_rand

  function automatic word_t exp_dword(dw_index_t dw);
    case (dw)
      DW_IDENT:  return {DEV, VEND};
      DW_CMDSTS: return {16'h0080, 14'h0000, cmd_r};
      DW_CLASS:  return {8'h08, 8'h80, 8'h00, REV};
      DW_HEADER: return 32'h0000_0000;
      DW_BAR:    return {bar_r, 12'h000};
      DW_BOARD:  return {stag_r, vtag_r};
      default:   return 32'h0000_0000;
    endcase
  endfunction : exp_dword

  task automatic model_write(dw_index_t dw, byte_en_t be, word_t wd);
    if (dw == DW_CMDSTS && be[0]) cmd_r = wd[1:0];
    if (dw == DW_BAR) begin
      if (be[1]) bar_r[3:0] = wd[15:12];
      if (be[2]) bar_r[11:4] = wd[23:16];
      if (be[3]) bar_r[19:12] = wd[31:24];
    end
    if (dw == DW_BOARD && !vlock_r && |be[1:0]) begin
      if (be[0]) vtag_r[7:0] = wd[7:0];
      if (be[1]) vtag_r[15:8] = wd[15:8];
      vlock_r = 1'b1;
    end
    if (dw == DW_BOARD && !slock_r && |be[3:2]) begin
      if (be[2]) stag_r[7:0] = wd[23:16];
      if (be[3]) stag_r[15:8] = wd[31:24];
      slock_r = 1'b1;
    end
  endtask : model_write

  // *****
  // Port tasks, all entered at a falling edge
  // *****
  task automatic cfg_op(logic we, dw_index_t dw, byte_en_t be, word_t wd);
    cfg_req = 1'b1;
    cfg_we = we;
    cfg_dw = dw;
    cfg_be = be;
    cfg_wdata = wd;
    mem_req = 1'b0;
    io_req = 1'b0;
    if (we) model_write(dw, be, wd);
    @(negedge clk_in);
    `CHK(cfg_ack, 1'b1)
    if (!we) `CHK(cfg_rdata, exp_dword(dw))
    `CHK(mem_en, cmd_r[1])
    `CHK(io_en, cmd_r[0])
  endtask : cfg_op

  task automatic mem_probe(word_t addr);
    mem_req = 1'b1;
    mem_addr = addr;
    cfg_req = 1'b0;
    io_req = 1'b0;
    @(negedge clk_in);
    `CHK(mem_hit, cmd_r[1] && addr[31:12] == bar_r)
  endtask : mem_probe

  task automatic io_probe(half_t addr);
    io_req = 1'b1;
    io_addr = addr;
    cfg_req = 1'b0;
    mem_req = 1'b0;
    @(negedge clk_in);
    `CHK(io_hit, cmd_r[0] && addr >= io_lo && addr <= io_hi)
  endtask : io_probe

  task automatic do_reset();
    reset_n_in = 1'b0;
    cfg_req = 1'b0;
    mem_req = 1'b0;
    io_req = 1'b0;
    {cmd_r, bar_r, vtag_r, stag_r, vlock_r, slock_r} = '0;
    @(negedge clk_in);
    `CHK({cfg_ack, mem_en, io_en, mem_hit, io_hit, cfg_rdata}, 37'h0_0000_0000)
    repeat (2) @(negedge clk_in);
    reset_n_in = 1'b1;
    @(negedge clk_in);
    cfg_op(1'b0, DW_CMDSTS, 4'hF, '0);
    cfg_op(1'b0, DW_BAR, 4'hF, '0);
    cfg_op(1'b0, DW_BOARD, 4'hF, '0);
  endtask : do_reset

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : complete_run

  // *****
  // Sequence
  // *****
  initial begin
    {cmd_r, bar_r, vtag_r, stag_r, vlock_r, slock_r} = '0;
    repeat (16) @(negedge clk_in);
    reset_n_in = 1'b1;
    @(negedge clk_in);
    for (int i = 0; i < 64; i++) cfg_op(1'b0, i[5:0], 4'hF, '0);
    // One lane locks only its own tag; the other stays open
    cfg_op(1'b1, DW_BOARD, 4'b0001, 32'h1234_56A5);
    cfg_op(1'b1, DW_BOARD, 4'hF, next_rand());
    cfg_op(1'b1, DW_BOARD, 4'hF, next_rand());
    cfg_op(1'b0, DW_BOARD, 4'hF, '0);
    do_reset();
    for (int i = 0; i < 64; i++) cfg_op(1'b1, i[5:0], 4'hF, 32'hFFFF_FFFF);
    for (int i = 0; i < 64; i++) cfg_op(1'b0, i[5:0], 4'hF, '0);
    // Frozen clock enable: request must not be taken; idle first so ack freezes low
    cfg_req = 1'b0;
    @(negedge clk_in);
    ce_in = 1'b0;
    cfg_req = 1'b1;
    cfg_we = 1'b1;
    cfg_dw = DW_CMDSTS;
    cfg_be = 4'h1;
    cfg_wdata = '0;
    @(negedge clk_in);
    `CHK({cfg_ack, mem_en}, 2'b01)
    ce_in = 1'b1;
    cfg_req = 1'b0;
    @(negedge clk_in);
    for (int n = 0; n < 600; n++) begin
      logic [31:0] r;
      dw_index_t   dw;
      r = next_rand();
      dw = r[2] ? r[13:8] : (r[4:3] == 2'd0 ? DW_CMDSTS : (r[3] ? DW_BAR : DW_BOARD));
      if (n == 300) do_reset();
      case (r[1:0])
        2'd0: cfg_op(1'b1, dw, r[19:16], next_rand());
        2'd1: cfg_op(1'b0, dw, r[19:16], '0);
        2'd2: mem_probe(r[20] ? {bar_r, r[31:20]} : next_rand());
        default: begin
          io_lo = r[31:16];
          io_hi = r[31:16] + {12'h000, r[11:8]};
          case (r[15:14])
            2'd0: io_probe(io_lo);
            2'd1: io_probe(io_hi);
            2'd2: io_probe(io_lo - 16'h0001);
            default: io_probe(r[5] ? io_hi + 16'h0001 : next_rand());
          endcase
        end
      endcase
    end
    complete_run();
  end

  initial begin
    #200_000;
    n_mismatch++;
    complete_run();
  end

endmodule : overflow_device_config_header_test
